// [rtl/scale_timing_pkg.sv]
// Package: register map, reset values and types for the current scale timing block
`default_nettype none
package scale_timing_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STANDBY_ENTRY_DELAY   = 8'h15;
  localparam logic [7:0] IDX_FREEWHEEL_ENTRY_DELAY = 8'h16;
  localparam logic [7:0] IDX_DRIVE_VELOCITY_THRESH = 8'h17;
  localparam logic [7:0] IDX_RISE_INTERVAL         = 8'h18;
  localparam logic [7:0] IDX_FALL_TO_HOLD_INTERVAL = 8'h19;
  localparam logic [7:0] IDX_DRIVE_FALL_INTERVAL   = 8'h1a;
  localparam logic [7:0] IDX_BOOST_WINDOW_CYCLES   = 8'h1b;
  localparam logic [7:0] IDX_APPLIED_SCALE         = 8'h7c;
  localparam logic [7:0] IDX_SCALE_CONTROL         = 8'h7d;
  localparam logic [7:0] IDX_SCALE_VALUES          = 8'h7e;
  localparam logic [7:0] IDX_PRESENT_VELOCITY      = 8'h7f;
  localparam int         ADDR_W                    = 10;
  // Control register fields
  localparam int BIT_CLOSED_LOOP  = 0;
  localparam int BIT_PWM_MODE     = 1;
  localparam int BIT_FREEWHEEL_EN = 2;
  localparam int BIT_COARSE_FMT   = 3;
  // Reset values
  localparam logic [31:0] RST_DELAY32   = 32'h0000_0000;
  localparam logic [23:0] RST_DELAY24   = 24'h00_0000;
  localparam logic [31:0] RST_SCALE_VAL = 32'hffff_ffff;
  localparam logic [7:0]  RST_APPLIED   = 8'hff;
  localparam logic [8:0]  RST_WRAP      = 9'h000;
  localparam logic [3:0]  RST_CONTROL   = 4'h0;
  // Scale value field positions within the scale values register
  localparam int POS_BOOST = 0;
  localparam int POS_DRV1  = 8;
  localparam int POS_DRV2  = 16;
  localparam int POS_HOLD  = 24;
  // Motion phase after a ramp
  typedef enum logic [1:0] {
    PH_MOVING    = 2'b00,
    PH_STOP_WAIT = 2'b01,
    PH_STANDBY   = 2'b10,
    PH_FREEWHEEL = 2'b11
  } phase_t;
endpackage : scale_timing_pkg
`default_nettype wire

// [rtl/step_delay_timer.sv]
// Step delay timer: periodic one-cycle tick, restartable
`default_nettype none
module step_delay_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        restart_in,
  input  wire logic        run_in,
  input  wire logic [31:0] period_in,
  output logic             tick_out
);
  logic [31:0] count;

  // Counts up while running; a zero period ticks every cycle
  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in || !run_in) begin
      count    <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (count >= period_in) begin
      count    <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end
endmodule : step_delay_timer
`default_nettype wire

// [rtl/scale_timing.sv]
// Motor current scale selection and step timing with Wishbone register slave
// Behaviour
// - Wait standby delay after ramp stop
// - Wait freewheel_entry_delay after standby begins
// - Velocity above threshold selects second drive, outside PWM mode
// - PWM mode: threshold is full amplitude velocity
// - Open loop: raise scale per rise interval
// - Closed loop: same register, rise interval
// - Open loop: lower toward hold per interval
// - Closed loop: same register, fall interval
// - Lower toward drive per drive interval
// - Boost active for boost cycles after start
// - Read applied scale; write sets wrap fraction
// - Scale x means (x+1)/32 or /256
//
// Local design decision: the Wishbone slave port.
`default_nettype none
module scale_timing
  import scale_timing_pkg::*;
(
  input  wire logic                         CLOCK_IN,
  input  wire logic                         RST_IN,
  input  wire logic                         WB_CYC_IN,
  input  wire logic                         WB_STB_IN,
  input  wire logic                         WB_WE_IN,
  input  wire logic [scale_timing_pkg::ADDR_W-1:0] WB_ADR_IN,
  input  wire logic [3:0]                   WB_SEL_IN,
  input  wire logic [31:0]                  WB_DAT_IN,
  output logic      [31:0]                  WB_DAT_OUT,
  output logic                              WB_ACK_OUT,
  input  wire logic                         RAMP_START_IN,
  input  wire logic                         RAMP_STOPPED_IN,
  output logic      [7:0]                   SCALE_OUT,
  output logic                              COARSE_FORMAT_OUT,
  output logic                              STANDBY_OUT,
  output logic                              FREEWHEEL_OUT,
  output logic      [23:0]                  PWM_FULL_AMPLITUDE_VELOCITY_OUT
);
  import scale_timing_pkg::*;

  logic [31:0] standby_entry_delay;
  logic [31:0] freewheel_entry_delay;
  logic [23:0] drive_velocity_threshold;
  logic [23:0] rise_interval;
  logic [23:0] fall_to_hold_interval;
  logic [23:0] drive_fall_interval;
  logic [31:0] boost_window_cycles;
  logic [31:0] scale_values;
  logic [3:0]  control;
  logic [8:0]  wrap_fraction_setting;
  logic [23:0] present_velocity;
  logic [7:0]  applied;
  logic [7:0]  target;
  logic [7:0]  next_target;
  logic [31:0] boost_count;
  logic        boost_active;
  logic [31:0] phase_count;
  phase_t      phase;
  logic        ramp_start_s1, ramp_start_s2;
  logic        ramp_stop_s1, ramp_stop_s2;
  logic        rise_tick, hold_tick, drive_tick;
  logic        wb_req, wb_wr;
  logic [7:0]  word_idx;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Hold current applies in standby and while freewheeling
  function automatic logic at_rest(input phase_t ph);
    return (ph == PH_STANDBY) || (ph == PH_FREEWHEEL);
  endfunction : at_rest

  // Two-flop synchronisers for ramp status pins
  // Pins are asynchronous; only the second flop feeds any logic
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ramp_start_s1 <= 1'b0;
      ramp_start_s2 <= 1'b0;
      ramp_stop_s1  <= 1'b0;
      ramp_stop_s2  <= 1'b0;
    end else begin
      ramp_start_s1 <= RAMP_START_IN;
      ramp_start_s2 <= ramp_start_s1;
      ramp_stop_s1  <= RAMP_STOPPED_IN;
      ramp_stop_s2  <= ramp_stop_s1;
    end
  end

  // Request taken only while ack is low, so each request gets one ack
  assign wb_req   = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign wb_wr    = wb_req && WB_WE_IN;
  assign word_idx = WB_ADR_IN[ADDR_W-1:2];

  // Register writes; applied scale index writes go to wrap fraction instead
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      standby_entry_delay      <= RST_DELAY32;
      freewheel_entry_delay    <= RST_DELAY32;
      drive_velocity_threshold <= RST_DELAY24;
      rise_interval            <= RST_DELAY24;
      fall_to_hold_interval    <= RST_DELAY24;
      drive_fall_interval      <= RST_DELAY24;
      boost_window_cycles      <= RST_DELAY32;
      scale_values             <= RST_SCALE_VAL;
      control                  <= RST_CONTROL;
      wrap_fraction_setting    <= RST_WRAP;
      present_velocity         <= RST_DELAY24;
    end else if (wb_wr) begin
      case (word_idx)
        IDX_STANDBY_ENTRY_DELAY:   standby_entry_delay <= merge(standby_entry_delay, WB_DAT_IN, WB_SEL_IN);
        IDX_FREEWHEEL_ENTRY_DELAY: freewheel_entry_delay <= merge(freewheel_entry_delay, WB_DAT_IN, WB_SEL_IN);
        IDX_DRIVE_VELOCITY_THRESH:
          drive_velocity_threshold <= 24'(merge({8'h00, drive_velocity_threshold}, WB_DAT_IN, WB_SEL_IN));
        IDX_RISE_INTERVAL:         rise_interval <= 24'(merge({8'h00, rise_interval}, WB_DAT_IN, WB_SEL_IN));
        IDX_FALL_TO_HOLD_INTERVAL:
          fall_to_hold_interval <= 24'(merge({8'h00, fall_to_hold_interval}, WB_DAT_IN, WB_SEL_IN));
        IDX_DRIVE_FALL_INTERVAL:
          drive_fall_interval <= 24'(merge({8'h00, drive_fall_interval}, WB_DAT_IN, WB_SEL_IN));
        IDX_BOOST_WINDOW_CYCLES:   boost_window_cycles <= merge(boost_window_cycles, WB_DAT_IN, WB_SEL_IN);
        IDX_APPLIED_SCALE:
          wrap_fraction_setting <= 9'(merge({23'h0, wrap_fraction_setting}, WB_DAT_IN, WB_SEL_IN));
        IDX_SCALE_CONTROL:         control <= 4'(merge({28'h0, control}, WB_DAT_IN, WB_SEL_IN));
        IDX_SCALE_VALUES:          scale_values <= merge(scale_values, WB_DAT_IN, WB_SEL_IN);
        IDX_PRESENT_VELOCITY:
          present_velocity <= 24'(merge({8'h00, present_velocity}, WB_DAT_IN, WB_SEL_IN));
        default: ;
      endcase
    end
  end

  // Read mux and one-cycle ack; unmapped reads return zero
  // Registered ack costs a wait state but keeps decode off the bus path
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        case (word_idx)
          IDX_STANDBY_ENTRY_DELAY:   WB_DAT_OUT <= standby_entry_delay;
          IDX_FREEWHEEL_ENTRY_DELAY: WB_DAT_OUT <= freewheel_entry_delay;
          IDX_DRIVE_VELOCITY_THRESH: WB_DAT_OUT <= {8'h00, drive_velocity_threshold};
          IDX_RISE_INTERVAL:         WB_DAT_OUT <= {8'h00, rise_interval};
          IDX_FALL_TO_HOLD_INTERVAL: WB_DAT_OUT <= {8'h00, fall_to_hold_interval};
          IDX_DRIVE_FALL_INTERVAL:   WB_DAT_OUT <= {8'h00, drive_fall_interval};
          IDX_BOOST_WINDOW_CYCLES:   WB_DAT_OUT <= boost_window_cycles;
          IDX_APPLIED_SCALE:         WB_DAT_OUT <= {23'h0, boost_active, applied};
          IDX_SCALE_CONTROL:         WB_DAT_OUT <= {17'h0, wrap_fraction_setting, phase, control};
          IDX_SCALE_VALUES:          WB_DAT_OUT <= scale_values;
          IDX_PRESENT_VELOCITY:      WB_DAT_OUT <= {8'h00, present_velocity};
          default:                   WB_DAT_OUT <= 32'h0000_0000;
        endcase
      end else begin
        WB_DAT_OUT <= 32'h0000_0000;
      end
    end
  end

  // Boost window restarts on every ramp start
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      boost_count  <= RST_DELAY32;
      boost_active <= 1'b0;
    end else if (ramp_start_s2) begin
      boost_count  <= boost_window_cycles;
      boost_active <= (boost_window_cycles != 32'h0000_0000);
    end else if (boost_count != 32'h0000_0000) begin
      boost_count  <= boost_count - 32'h0000_0001;
      boost_active <= (boost_count != 32'h0000_0001);
    end else begin
      boost_active <= 1'b0;
    end
  end

  // Stop, standby and freewheel sequencing; a zero delay passes on the next cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      phase       <= PH_MOVING;
      phase_count <= RST_DELAY32;
    end else if (!ramp_stop_s2 || ramp_start_s2) begin
      phase       <= PH_MOVING;
      phase_count <= RST_DELAY32;
    end else begin
      case (phase)
        PH_MOVING: begin
          phase       <= PH_STOP_WAIT;
          phase_count <= RST_DELAY32;
        end
        PH_STOP_WAIT: begin
          if (phase_count >= standby_entry_delay) begin
            phase       <= PH_STANDBY;
            phase_count <= RST_DELAY32;
          end else begin
            phase_count <= phase_count + 32'h0000_0001;
          end
        end
        PH_STANDBY: begin
          // Count saturates so a long stay cannot wrap back below the delay
          if (control[BIT_FREEWHEEL_EN] && phase_count >= freewheel_entry_delay) begin
            phase <= PH_FREEWHEEL;
          end else if (phase_count != 32'hffff_ffff) begin
            phase_count <= phase_count + 32'h0000_0001;
          end
        end
        PH_FREEWHEEL: phase <= PH_FREEWHEEL;
        default:      phase <= PH_MOVING;
      endcase
    end
  end

  // Target selection: boost, hold, or drive by velocity threshold
  always_comb begin
    if (at_rest(phase)) begin
      next_target = scale_values[POS_HOLD +: 8];
    end else if (boost_active) begin
      next_target = scale_values[POS_BOOST +: 8];
    end else if (!control[BIT_PWM_MODE] && present_velocity > drive_velocity_threshold) begin
      next_target = scale_values[POS_DRV2 +: 8];
    end else begin
      next_target = scale_values[POS_DRV1 +: 8];
    end
  end

  // Target register; a difference from next_target restarts the timers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      target <= RST_APPLIED;
    end else begin
      target <= next_target;
    end
  end

  // Interval timers; each restarts when the target moves
  // Both fall timers run together; the phase picks which one steps
  step_delay_timer rise_timer (
    .clk_in     (CLOCK_IN),
    .rst_in     (RST_IN),
    .restart_in (next_target != target),
    .run_in     (applied < target),
    .period_in  ({8'h00, rise_interval}),
    .tick_out   (rise_tick)
  );

  step_delay_timer hold_timer (
    .clk_in     (CLOCK_IN),
    .rst_in     (RST_IN),
    .restart_in (next_target != target),
    .run_in     (applied > target),
    .period_in  ({8'h00, fall_to_hold_interval}),
    .tick_out   (hold_tick)
  );

  step_delay_timer drive_timer (
    .clk_in     (CLOCK_IN),
    .rst_in     (RST_IN),
    .restart_in (next_target != target),
    .run_in     (applied > target),
    .period_in  ({8'h00, drive_fall_interval}),
    .tick_out   (drive_tick)
  );

  // Step the applied scale one unit toward target; stops once equal
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      applied <= RST_APPLIED;
    end else if (next_target != target) begin
      applied <= applied;
    end else if (applied < target && rise_tick) begin
      applied <= applied + 8'h01;
    end else if (applied > target && at_rest(phase) && hold_tick) begin
      applied <= applied - 8'h01;
    end else if (applied > target && !at_rest(phase) && drive_tick) begin
      applied <= applied - 8'h01;
    end
  end

  // Driver-facing outputs, all registered
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SCALE_OUT                       <= RST_APPLIED;
      COARSE_FORMAT_OUT               <= 1'b0;
      STANDBY_OUT                     <= 1'b0;
      FREEWHEEL_OUT                   <= 1'b0;
      PWM_FULL_AMPLITUDE_VELOCITY_OUT <= RST_DELAY24;
    end else begin
      SCALE_OUT         <= applied;
      COARSE_FORMAT_OUT <= control[BIT_COARSE_FMT];
      STANDBY_OUT       <= at_rest(phase);
      FREEWHEEL_OUT     <= (phase == PH_FREEWHEEL);
      PWM_FULL_AMPLITUDE_VELOCITY_OUT <= control[BIT_PWM_MODE] ? drive_velocity_threshold : RST_DELAY24;
    end
  end
endmodule : scale_timing
`default_nettype wire

// [tb/scale_timing_chk.sv]
// Checker: bus, stepping and standby properties of the scale timing block
`default_nettype none
module scale_timing_chk (
  input wire logic        CLOCK_IN,
  input wire logic        RST_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        RAMP_START_IN,
  input wire logic        RAMP_STOPPED_IN,
  input wire logic [7:0]  SCALE_OUT,
  input wire logic        COARSE_FORMAT_OUT,
  input wire logic        STANDBY_OUT,
  input wire logic        FREEWHEEL_OUT,
  input wire logic [23:0] PWM_FULL_AMPLITUDE_VELOCITY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // Bus answers one cycle after taking a request, for one cycle only
  a_ack_next_cycle: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack missing one cycle after request");
  a_ack_single_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  a_data_quiet: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("read data outside ack");
  // Applied scale only ever moves one step at a time
  a_scale_unit_step: assert property ($changed(SCALE_OUT) |->
    SCALE_OUT == $past(SCALE_OUT) + 8'h01 || SCALE_OUT == $past(SCALE_OUT) - 8'h01)
    else $error("scale jumped by more than one step");
  a_freewheel_in_standby: assert property (FREEWHEEL_OUT |-> STANDBY_OUT)
    else $error("freewheel outside standby");
  // Synchroniser, phase and output flops: the stop pin seen four and five edges back
  a_standby_cause: assert property ($rose(STANDBY_OUT) |->
    $past(RAMP_STOPPED_IN, 4) && $past(RAMP_STOPPED_IN, 5))
    else $error("standby without a settled ramp stop");
  a_standby_leave: assert property ($fell(STANDBY_OUT) |->
    !$past(RAMP_STOPPED_IN, 3) || !$past(RAMP_STOPPED_IN, 4) || $past(RAMP_START_IN, 3) || $past(RAMP_START_IN, 4))
    else $error("standby left while ramp still stopped");
  a_pwm_after_write: assert property ($changed(PWM_FULL_AMPLITUDE_VELOCITY_OUT) |->
    $past(WB_ACK_OUT && WB_WE_IN) || $past(WB_ACK_OUT && WB_WE_IN, 2))
    else $error("full amplitude velocity changed without a write");
  a_format_after_write: assert property ($changed(COARSE_FORMAT_OUT) |->
    $past(WB_ACK_OUT && WB_WE_IN) || $past(WB_ACK_OUT && WB_WE_IN, 2))
    else $error("format changed without a write");
  c_read: cover property (WB_ACK_OUT && !WB_WE_IN);
  c_standby: cover property ($rose(STANDBY_OUT));
  c_freewheel: cover property ($rose(FREEWHEEL_OUT));
  c_step: cover property ($changed(SCALE_OUT));
endmodule : scale_timing_chk
bind scale_timing scale_timing_chk i_chk (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
  .RAMP_START_IN(RAMP_START_IN), .RAMP_STOPPED_IN(RAMP_STOPPED_IN), .SCALE_OUT(SCALE_OUT),
  .COARSE_FORMAT_OUT(COARSE_FORMAT_OUT), .STANDBY_OUT(STANDBY_OUT), .FREEWHEEL_OUT(FREEWHEEL_OUT),
  .PWM_FULL_AMPLITUDE_VELOCITY_OUT(PWM_FULL_AMPLITUDE_VELOCITY_OUT));
`default_nettype wire

// [tb/scale_driver_model.sv]
// Behavioural motor driver taking current scale updates
`default_nettype none
module scale_driver_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] scale_in,
  output var int          gap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  logic [7:0] last;
  // Falling edge sampling keeps clear of the update edge
  always @(negedge clk_in) begin
    last <= scale_in;
    cnt <= (rst_in || scale_in !== last) ? 1 : cnt + 1;
    if (!rst_in && scale_in !== last) begin
      gap_out <= cnt; // Cycles between two applied steps
    end
  end
endmodule : scale_driver_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the current scale timing block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import scale_timing_pkg::*;
  logic              clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, start = 0, stopped = 0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0]        sel = 4'hf;
  logic [31:0]       dat = 32'h0, rdat, d, x = 32'h55;
  logic              ack, stdby, fw, coarse;
  logic [7:0]        scale, prev = 8'hff;
  logic [23:0]       pwm;
  logic [31:0]       exp_rd[$];
  logic [7:0]        exp_sc[$];
  int                n_mismatch = 0, checks = 0, gap, n, t1[3], f1[3];
  always #12.5 clk = ~clk;
  scale_timing i_dut (.CLOCK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .RAMP_START_IN(start), .RAMP_STOPPED_IN(stopped), .SCALE_OUT(scale), .COARSE_FORMAT_OUT(coarse),
    .STANDBY_OUT(stdby), .FREEWHEEL_OUT(fw), .PWM_FULL_AMPLITUDE_VELOCITY_OUT(pwm));
  scale_driver_model i_drv (.clk_in(clk), .rst_in(rst), .scale_in(scale), .gap_out(gap));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  // Classic single cycle; holds the request until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] v, input logic [31:0] e = 0,
                    input logic [3:0] s = 4'hf);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat <= v;
    if (!w) exp_rd.push_back(e);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_mismatch++; // Missing ack counts as a failure
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic final_report;
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Monitor: read data taken at the rising edge where ack is sampled, scale on each change, against the oldest note
  always @(posedge clk) begin
    prev <= scale;
    if (ack === 1'b1 && we === 1'b0) check(rdat, exp_rd.size() ? exp_rd.pop_front() : 'x, "read data");
    if (!rst && scale !== prev) check(scale, exp_sc.size() ? exp_sc.pop_front() : 'x, "scale");
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values, byte merge, random readback, unmapped place
    for (int i = 'h15; i <= 'h1b; i++) wb(0, 8'(i), 0, 0);
    wb(0, IDX_SCALE_VALUES, 0, RST_SCALE_VAL);
    wb(1, IDX_STANDBY_ENTRY_DELAY, 32'hffff_ffff, 0, 4'h2);
    wb(0, IDX_STANDBY_ENTRY_DELAY, 0, 32'h0000_ff00);
    for (int i = 'h15; i <= 'h1b; i++) begin
      d = rnd();
      wb(1, 8'(i), d);
      wb(0, 8'(i), 0, (i >= 'h17 && i <= 'h1a) ? {8'h0, d[23:0]} : d);
    end
    wb(1, 8'h40, rnd());
    wb(0, 8'h40, 0, 0);
    // Stepping down toward first drive, interval 2 gives a step every 3 cycles
    wb(1, IDX_RISE_INTERVAL, 0);
    wb(1, IDX_FALL_TO_HOLD_INTERVAL, 1);
    wb(1, IDX_DRIVE_FALL_INTERVAL, 2);
    wb(1, IDX_DRIVE_VELOCITY_THRESH, 'h50);
    wb(1, IDX_PRESENT_VELOCITY, 'h50);
    exp_sc = {exp_sc, 8'hfe, 8'hfd, 8'hfc};
    wb(1, IDX_SCALE_VALUES, 32'hfaf8_fcfe);
    repeat (20) @(posedge clk);
    check(gap, 3, "drive fall gap");
    exp_sc = {exp_sc, 8'hfb, 8'hfa, 8'hf9, 8'hf8};
    wb(1, IDX_PRESENT_VELOCITY, 'h51);
    repeat (20) @(posedge clk);
    exp_sc = {exp_sc, 8'hf9, 8'hfa, 8'hfb, 8'hfc};
    wb(1, IDX_PRESENT_VELOCITY, 0);
    repeat (10) @(posedge clk);
    check(gap, 1, "rise gap");
    // Boost after a ramp start, then back to first drive
    exp_sc = {exp_sc, 8'hfd, 8'hfe, 8'hfd, 8'hfc};
    wb(1, IDX_BOOST_WINDOW_CYCLES, 30);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (60) @(posedge clk);
    wb(1, IDX_APPLIED_SCALE, 32'h1ff);
    wb(0, IDX_APPLIED_SCALE, 0, 32'h0fc);
    wb(1, IDX_SCALE_CONTROL, 'he);
    wb(0, IDX_SCALE_CONTROL, 0, 32'h0000_7fce);
    repeat (3) @(posedge clk);
    check(pwm, 'h50, "full amplitude velocity");
    check(coarse, 1, "coarse format");
    wb(1, IDX_SCALE_CONTROL, 'h5);
    repeat (3) @(posedge clk);
    check(pwm, 0, "full amplitude velocity");
    // Standby and freewheel entry at three delays; only the differences are fixed
    for (int k = 0; k < 3; k++) begin
      wb(1, IDX_STANDBY_ENTRY_DELAY, k == 0 ? 2 : k == 1 ? 5 : 20);
      wb(1, IDX_FREEWHEEL_ENTRY_DELAY, k == 0 ? 1 : k == 1 ? 5 : 13);
      exp_sc = {exp_sc, 8'hfb, 8'hfa, 8'hfb, 8'hfc};
      stopped <= 1'b1;
      for (n = 0; n < 200 && stdby !== 1'b1; n++) @(negedge clk);
      t1[k] = n;
      for (n = 0; n < 200 && fw !== 1'b1; n++) @(negedge clk);
      f1[k] = n;
      @(posedge clk);
      stopped <= 1'b0;
      repeat (30) @(posedge clk);
    end
    check(t1[1] - t1[0], 3, "standby delay");
    check(t1[2] - t1[1], 15, "standby delay");
    check(f1[1] - f1[0], 4, "freewheel_entry_delay");
    check(f1[2] - f1[1], 8, "freewheel_entry_delay");
    check(exp_sc.size() + exp_rd.size(), 0, "pending notes");
    final_report();
  end
endmodule : testbench
`default_nettype wire
